// *** src/fosr_core.sv ***
// operand selection, conditioning and result rounding for the fp pair
`include "fosr_consts.svh"

module fosr_core #(
  parameter int WIDTH = 32,
  parameter int MC_CYCLES = `FOSR_MC_CYCLES_DEF,
  parameter int CORE_LATENCY = `FOSR_CORE_LATENCY_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  // input register loading
  input wire logic load_a,
  input wire logic load_a_index,
  input wire logic [WIDTH-1:0] load_a_data,
  input wire logic load_b,
  input wire logic load_b_index,
  input wire logic [WIDTH-1:0] load_b_data,
  // registered controls from the sequencer
  input wire logic read_operands,
  input wire fosr_pkg::fosr_ctrl_s ctrl_in,
  // conditioned operands towards the arithmetic core
  output logic operand_valid,
  output logic [WIDTH-1:0] operand_a,
  output logic [WIDTH-1:0] operand_b,
  output fosr_pkg::fosr_ctrl_s operand_ctrl,
  output logic busy,
  // unrounded result back from the core
  input wire logic raw_valid,
  input wire fosr_pkg::fosr_raw_s raw_in,
  // rounded result
  output logic result_valid,
  output logic [WIDTH-1:0] result,
  output logic result_inexact,
  output logic result_overflow,
  output logic round_illegal
);

  // mc_count is 8 bits wide, hence the upper limit on MC_CYCLES
  if (WIDTH != 32) begin : g_bad_width
    $error("fosr_core: only 32-bit operands are served");
  end
  if (MC_CYCLES < 2 || MC_CYCLES > 255) begin : g_bad_mc
    $error("fosr_core: MC_CYCLES must lie in 2..255");
  end
  if (CORE_LATENCY < 1 || CORE_LATENCY > 16) begin : g_bad_lat
    $error("fosr_core: CORE_LATENCY must lie in 1..16");
  end

  // ==========================================================
  // input register bank
  // ==========================================================
  logic [WIDTH-1:0] reg_a [2];
  logic [WIDTH-1:0] reg_b [2];

  // the sequencer keeps multicycle operands stable
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_a[0] <= '0;
      reg_a[1] <= '0;
    end else if (load_a) begin
      reg_a[load_a_index] <= load_a_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_b[0] <= '0;
      reg_b[1] <= '0;
    end else if (load_b) begin
      reg_b[load_b_index] <= load_b_data;
    end
  end

  // ==========================================================
  // multicycle sequencing
  // ==========================================================
  fosr_pkg::fosr_state_e state;
  logic [7:0] mc_count;
  fosr_pkg::fosr_ctrl_s held_ctrl;
  logic start_mc;

  assign start_mc = read_operands && ctrl_in.multicycle &&
      state == fosr_pkg::FOSR_IDLE;
  assign busy = (state == fosr_pkg::FOSR_BUSY);

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= fosr_pkg::FOSR_IDLE;
      mc_count <= 8'h00;
    end else begin
      case (state)
        fosr_pkg::FOSR_IDLE: begin
          if (start_mc) begin
            state <= fosr_pkg::FOSR_BUSY;
            mc_count <= 8'(MC_CYCLES - 1);
          end
        end
        fosr_pkg::FOSR_BUSY: begin
          if (mc_count == 8'h01) begin
            state <= fosr_pkg::FOSR_IDLE;
          end
          mc_count <= mc_count - 8'h01;
        end
        default: begin
          state <= fosr_pkg::FOSR_IDLE;
        end
      endcase
    end
  end

  // selection frozen for the whole operation
  always_ff @(posedge mclk) begin
    if (reset) begin
      held_ctrl <= '0;
    end else if (start_mc) begin
      held_ctrl <= ctrl_in;
    end
  end

  // ==========================================================
  // operand selection and conditioning
  // ==========================================================
  fosr_pkg::fosr_ctrl_s eff_ctrl;
  logic [WIDTH-1:0] pick_a;
  logic [WIDTH-1:0] pick_b;

  // magnitude: sign clear for floats, negate negative signed fixed
  function automatic logic [31:0] magnitude(input logic [31:0] v,
                                            input logic sp,
                                            input logic tc);
    logic [31:0] m;
    m = v;
    if (sp) begin
      m[`FOSR_SIGN_BIT] = 1'b0;
    end else if (tc && v[`FOSR_SIGN_BIT]) begin
      m = 32'h0 - v;
    end
    return m;
  endfunction

  // while busy the sequencer's selection is not looked at
  assign eff_ctrl = busy ? held_ctrl : ctrl_in;

  // bypass when the selected register is written this edge
  always_comb begin
    pick_a = reg_a[eff_ctrl.sel_a];
    pick_b = reg_b[eff_ctrl.sel_b];
    if (load_a && load_a_index == eff_ctrl.sel_a) begin
      pick_a = load_a_data;
    end
    if (load_b && load_b_index == eff_ctrl.sel_b) begin
      pick_b = load_b_data;
    end
  end

  // controls and operands captured together on the read edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      operand_valid <= 1'b0;
      operand_a <= '0;
      operand_b <= '0;
      operand_ctrl <= '0;
    end else begin
      operand_valid <= read_operands || busy;
      if (read_operands || busy) begin
        operand_ctrl <= eff_ctrl;
        // fixed-point signedness only matters off floating point
        operand_ctrl.signed_a <= eff_ctrl.signed_a &&
          !eff_ctrl.single_precision;
        operand_ctrl.signed_b <= eff_ctrl.signed_b &&
          !eff_ctrl.single_precision;
        // wrap marks pass with the operand they describe
        operand_ctrl.wrap_a <= eff_ctrl.wrap_a && eff_ctrl.use_a;
        operand_ctrl.wrap_b <= eff_ctrl.wrap_b && eff_ctrl.use_b;
        operand_ctrl.dividend_wrapped <= eff_ctrl.dividend_wrapped &&
          eff_ctrl.use_a;
        operand_ctrl.divisor_wrapped <= eff_ctrl.divisor_wrapped &&
          eff_ctrl.use_b;
        // an unused bank feeds zero whatever its select says
        if (eff_ctrl.use_a) begin
          operand_a <= eff_ctrl.abs_a ?
            magnitude(pick_a, eff_ctrl.single_precision, eff_ctrl.signed_a) :
            pick_a;
        end else begin
          operand_a <= '0;
        end
        if (eff_ctrl.use_b) begin
          operand_b <= eff_ctrl.abs_b ?
            magnitude(pick_b, eff_ctrl.single_precision, eff_ctrl.signed_b) :
            pick_b;
        end else begin
          operand_b <= '0;
        end
      end
    end
  end

  // ==========================================================
  // control pipeline alongside the arithmetic core
  // ==========================================================
  fosr_pkg::fosr_ctrl_s ctrl_pipe [CORE_LATENCY];

  // round mode rides with its operands to the last stage
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_pipe[0] <= '0;
    end else if (operand_valid) begin
      ctrl_pipe[0] <= operand_ctrl;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < CORE_LATENCY; gi++) begin : g_pipe
      always_ff @(posedge mclk) begin
        if (reset) begin
          ctrl_pipe[gi] <= '0;
        end else begin
          ctrl_pipe[gi] <= ctrl_pipe[gi-1];
        end
      end
    end
  endgenerate

  // ==========================================================
  // rounding stage
  // ==========================================================
  fosr_pkg::fosr_rmode_t rmode;
  logic fp_mode;
  logic inc;
  logic inexact;
  logic [24:0] mant_sum;
  logic signed [10:0] exp_r;
  logic [22:0] frac_r;
  logic ovf;
  logic [63:0] shifted;
  logic [32:0] msp_sum;
  logic [31:0] next_result;
  logic next_illegal;

  assign rmode = ctrl_pipe[CORE_LATENCY-1].rmode;
  assign fp_mode = ctrl_pipe[CORE_LATENCY-1].single_precision;

  // increment decision shared by both formats
  function automatic logic round_up(input fosr_pkg::fosr_rmode_t m,
                                    input logic sign,
                                    input logic lsb,
                                    input logic g,
                                    input logic s);
    logic r;
    r = 1'b0;
    case (m)
      `FOSR_RND_NEAREST_EVEN: r = g && (s || lsb);
      `FOSR_RND_TOWARD_ZERO: r = 1'b0;
      `FOSR_RND_TOWARD_POS: r = (g || s) && !sign;
      `FOSR_RND_TOWARD_NEG: r = (g || s) && sign;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb begin
    shifted = raw_in.shift_left ? {raw_in.product[62:0], 1'b0} :
        raw_in.product;
    inexact = 1'b0;
    inc = 1'b0;
    mant_sum = '0;
    exp_r = raw_in.exp;
    frac_r = '0;
    ovf = 1'b0;
    msp_sum = '0;
    next_illegal = 1'b0;
    next_result = '0;
    if (fp_mode) begin
      // exact values never move: no guard or sticky, no step
      inexact = raw_in.guard || raw_in.sticky;
      inc = round_up(rmode, raw_in.sign, raw_in.mant[0], raw_in.guard,
          raw_in.sticky);
      mant_sum = {1'b0, raw_in.mant} + {24'h0, inc};
      if (mant_sum[24]) begin
        exp_r = raw_in.exp + 11'sh001;
        frac_r = mant_sum[23:1];
      end else begin
        frac_r = mant_sum[22:0];
      end
      ovf = !raw_in.is_inf && exp_r > `FOSR_EXP_LARGEST_NORMAL;
      if (raw_in.is_inf) begin
        next_result = {raw_in.sign, `FOSR_EXP_ALL_ONES, 23'h0};
      end else if (ovf) begin
        // overflow goes to infinity or largest normal by mode
        if (rmode == `FOSR_RND_NEAREST_EVEN ||
            (rmode == `FOSR_RND_TOWARD_POS && !raw_in.sign) ||
            (rmode == `FOSR_RND_TOWARD_NEG && raw_in.sign)) begin
          next_result = {raw_in.sign, `FOSR_EXP_ALL_ONES, 23'h0};
        end else begin
          next_result = {raw_in.sign, `FOSR_EXP_MAX_FIELD,
              `FOSR_FRAC_ALL_ONES};
        end
      end else if (exp_r < `FOSR_EXP_NORM_MIN) begin
        // results below the normal range are flushed to signed zero
        next_result = {raw_in.sign, 31'h0};
      end else begin
        next_result = {raw_in.sign, exp_r[7:0], frac_r};
      end
    end else begin
      // fixed point rounds the shifted upper product half
      inexact = |shifted[31:0];
      next_illegal = rmode[1];
      if (rmode == `FOSR_RND_NEAREST_EVEN) begin
        inc = round_up(rmode, 1'b0, shifted[32], shifted[31],
            |shifted[30:0]);
      end
      // code 01 and the illegal codes add nothing
      msp_sum = {1'b0, shifted[63:32]} + {32'h0, inc};
      next_result = msp_sum[31:0];
    end
  end

  // output register always holds the rounded value
  always_ff @(posedge mclk) begin
    if (reset) begin
      result_valid <= 1'b0;
      result <= '0;
      result_inexact <= 1'b0;
      result_overflow <= 1'b0;
      round_illegal <= 1'b0;
    end else begin
      result_valid <= raw_valid;
      if (raw_valid) begin
        result <= next_result;
        result_inexact <= inexact;
        result_overflow <= ovf;
        round_illegal <= next_illegal;
      end
    end
  end

endmodule // fosr_core

// *** shared/fosr_consts.svh ***
// constant values for the fp operand select and round block
`ifndef FOSR_CONSTS_SVH
`define FOSR_CONSTS_SVH

// round_mode_select encodings
`define FOSR_RND_NEAREST_EVEN 2'h0
`define FOSR_RND_TOWARD_ZERO 2'h1
`define FOSR_RND_TOWARD_POS 2'h2
`define FOSR_RND_TOWARD_NEG 2'h3

// single-precision field layout
`define FOSR_SIGN_BIT 31
`define FOSR_EXP_MSB 30
`define FOSR_EXP_LSB 23
`define FOSR_FRAC_MSB 22
`define FOSR_EXP_ALL_ONES 8'hFF
`define FOSR_EXP_LARGEST_NORMAL 11'sh0FE
`define FOSR_EXP_NORM_MIN 11'sh001
`define FOSR_EXP_MAX_FIELD 8'hFE
`define FOSR_FRAC_ALL_ONES 23'h7FFFFF

// default timing counts in clock cycles
`define FOSR_MC_CYCLES_DEF 8
`define FOSR_CORE_LATENCY_DEF 3

`endif

// *** shared/fosr_pkg.sv ***
// types shared by the fp operand select and round block
package fosr_pkg;

  typedef logic [1:0] fosr_rmode_t;

  typedef enum logic {
    FOSR_IDLE,
    FOSR_BUSY
  } fosr_state_e;

  // registered controls sampled on the operand read edge
  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic use_a;
    logic use_b;
    logic abs_a;
    logic abs_b;
    logic wrap_a;
    logic wrap_b;
    logic dividend_wrapped;
    logic divisor_wrapped;
    logic signed_a;
    logic signed_b;
    logic single_precision;
    logic multicycle;
    fosr_rmode_t rmode;
  } fosr_ctrl_s;

  // unrounded result from the arithmetic core
  typedef struct packed {
    logic sign;
    logic is_inf;
    logic signed [10:0] exp;
    logic [23:0] mant;
    logic guard;
    logic sticky;
    logic [63:0] product;
    logic shift_left;
  } fosr_raw_s;

endpackage

// *** tb/fosr_core_checker.sv ***
// assertion checker for the fp operand select and round block
module fosr_core_checker #(
  parameter int MC_CYCLES = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic read_operands,
  input wire fosr_pkg::fosr_ctrl_s ctrl_in,
  input wire logic operand_valid,
  input wire logic [31:0] operand_a,
  input wire logic [31:0] operand_b,
  input wire fosr_pkg::fosr_ctrl_s operand_ctrl,
  input wire logic busy,
  input wire logic raw_valid,
  input wire logic result_valid,
  input wire logic round_illegal
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // helper logic
  int bcnt;
  logic rd;
  assign rd = read_operands && !busy;
  // cycles spent busy so far in this run
  always_ff @(posedge mclk) begin
    if (reset || !busy) begin
      bcnt <= 0;
    end else begin
      bcnt <= bcnt + 1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========
  // properties
  read_valid_a: assert property (rd |=> operand_valid)
    else $error("no operand_valid after read");
  mode_travel_a: assert property (rd |=>
    operand_ctrl.rmode == $past(ctrl_in.rmode))
    else $error("round mode not captured with operands");
  abs_mag_a: assert property (rd && ctrl_in.abs_a &&
    ctrl_in.use_a && ctrl_in.single_precision |=> !operand_a[31])
    else $error("abs operand still negative");
  unused_zero_a: assert property (rd && !ctrl_in.use_b |=>
    operand_b == '0)
    else $error("unused bank operand not zero");
  float_unsigned_a: assert property (rd &&
    ctrl_in.single_precision |=> !operand_ctrl.signed_a &&
    !operand_ctrl.signed_b)
    else $error("signed flags kept in float");
  busy_start_a: assert property (rd && ctrl_in.multicycle |=> busy)
    else $error("multicycle start without busy");
  busy_hold_a: assert property (busy |=>
    operand_valid && $stable(operand_ctrl))
    else $error("selection changed while busy");
  busy_end_a: assert property ($fell(busy) |->
    $past(bcnt) == MC_CYCLES - 2)
    else $error("busy length wrong");
  result_follow_a: assert property (raw_valid |=> result_valid)
    else $error("no result_valid after raw_valid");
  cover property (rd && ctrl_in.multicycle);
  cover property (rd && !ctrl_in.use_b);
  cover property (round_illegal);
endmodule // fosr_core_checker

bind fosr_core fosr_core_checker #(.MC_CYCLES(MC_CYCLES))
  fosr_core_checker_inst (.mclk(mclk), .reset(reset),
  .read_operands(read_operands), .ctrl_in(ctrl_in),
  .operand_valid(operand_valid), .operand_a(operand_a),
  .operand_b(operand_b), .operand_ctrl(operand_ctrl), .busy(busy),
  .raw_valid(raw_valid), .result_valid(result_valid),
  .round_illegal(round_illegal));

// *** tb/fosr_core_model.sv ***
// stand-in arithmetic core returning a scripted unrounded result
module fosr_core_model #(
  parameter int CORE_LATENCY = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic operand_valid,
  input wire fosr_pkg::fosr_raw_s raw_next,
  output logic raw_valid,
  output fosr_pkg::fosr_raw_s raw_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CORE_LATENCY:0] pipe;
  // result returns exactly when its controls leave the pipe
  always_ff @(posedge mclk) begin
    if (reset) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[CORE_LATENCY-1:0], operand_valid};
    end
  end
  assign raw_valid = pipe[CORE_LATENCY-1];
  // no stale value between results
  assign raw_in = raw_valid ? raw_next : fosr_pkg::fosr_raw_s'(~raw_next);
endmodule // fosr_core_model

// *** tb/tb_top.sv ***
// self-checking bench for the fp operand select and round block
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MC = 4;
  localparam logic [63:0] P_ODD = 64'h12345679_80000000;
  localparam logic [63:0] P_EVEN = 64'h12345678_80000000;
  localparam logic [63:0] P_SH = 64'h091A2B3C_40000000;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic load_a = 1'h0;
  logic load_b = 1'h0;
  logic load_a_index = 1'h0;
  logic load_b_index = 1'h0;
  logic [31:0] load_a_data = '0;
  logic [31:0] load_b_data = '0;
  logic read_operands = 1'h0;
  fosr_pkg::fosr_ctrl_s ctrl_in = '0;
  fosr_pkg::fosr_ctrl_s operand_ctrl;
  fosr_pkg::fosr_ctrl_s base;
  fosr_pkg::fosr_raw_s raw_in;
  fosr_pkg::fosr_raw_s raw_next = '0;
  logic operand_valid, busy, raw_valid, result_valid;
  logic result_inexact, result_overflow, round_illegal;
  logic [31:0] operand_a, operand_b, result;
  int error_cnt = 0;
  int checks = 0;
  always #2 mclk = ~mclk;
  fosr_core #(.MC_CYCLES(MC), .CORE_LATENCY(1)) fosr_core_inst (
    .mclk(mclk), .reset(reset), .load_a(load_a),
    .load_a_index(load_a_index), .load_a_data(load_a_data),
    .load_b(load_b), .load_b_index(load_b_index),
    .load_b_data(load_b_data), .read_operands(read_operands),
    .ctrl_in(ctrl_in), .operand_valid(operand_valid),
    .operand_a(operand_a), .operand_b(operand_b),
    .operand_ctrl(operand_ctrl), .busy(busy), .raw_valid(raw_valid),
    .raw_in(raw_in), .result_valid(result_valid), .result(result),
    .result_inexact(result_inexact), .result_overflow(result_overflow),
    .round_illegal(round_illegal));
  fosr_core_model #(.CORE_LATENCY(1)) fosr_core_model_inst (
    .mclk(mclk), .reset(reset), .operand_valid(operand_valid),
    .raw_next(raw_next), .raw_valid(raw_valid), .raw_in(raw_in));
  // ==========
  // helpers
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic ld(input logic i, input logic [31:0] a, b);
    load_a = 1'h1;
    load_b = 1'h1;
    load_a_index = i;
    load_b_index = i;
    load_a_data = a;
    load_b_data = b;
  endtask
  // idle edge after each read keeps strobes from toggling in one step
  task automatic rd(input fosr_pkg::fosr_ctrl_s c);
    read_operands = 1'h1;
    ctrl_in = c;
    @(negedge mclk);
    read_operands = 1'h0;
    load_a = 1'h0;
    load_b = 1'h0;
    `CHK("operand_valid", 1'h1, operand_valid)
    @(negedge mclk);
  endtask
  function automatic fosr_pkg::fosr_raw_s fr(input logic [2:0] sgs,
      input logic [10:0] ex, input logic [23:0] mn);
    fr = '0;
    {fr.sign, fr.guard, fr.sticky} = sgs;
    fr.exp = ex;
    fr.mant = mn;
  endfunction
  function automatic fosr_pkg::fosr_raw_s fx(input logic [63:0] p,
      input logic sl);
    fx = '0;
    fx.product = p;
    fx.shift_left = sl;
  endfunction
  task automatic rnd(input logic sp, input logic [1:0] m,
      input fosr_pkg::fosr_raw_s r, input logic [31:0] e);
    fosr_pkg::fosr_ctrl_s c;
    c = base;
    c.single_precision = sp;
    c.rmode = m;
    raw_next = r;
    rd(c);
    ctrl_in.single_precision = ~sp; // late format change ignored
    for (int k = 0; k < 8 && result_valid !== 1'h1; k++) @(negedge mclk);
    `CHK("result_valid", 1'h1, result_valid)
    `CHK("result", e, result)
  endtask
  // ==========
  // scenarios
  task automatic t_select();
    fosr_pkg::fosr_ctrl_s c;
    c = base;
    for (int i = 0; i < 4; i++) begin
      c.sel_a = i[0];
      c.sel_b = i[1];
      // first two reads take freshly loaded data on the load edge, bank b in the first read only
      if (i < 2) ld(i[0], {31'h50, i[0]}, {31'h58, i[0]});
      rd(c);
      `CHK("operand_a", {31'h50, c.sel_a}, operand_a)
      `CHK("operand_b", {31'h58, c.sel_b}, operand_b)
    end
  endtask
  task automatic t_unused();
    fosr_pkg::fosr_ctrl_s c;
    c = base;
    c.use_b = 1'h0;
    c.sel_b = 1'h1;
    c.wrap_b = 1'h1;
    rd(c);
    `CHK("operand_b", 32'h00000000, operand_b)
    `CHK("wrap_b", 1'h0, operand_ctrl.wrap_b)
  endtask
  task automatic t_abs();
    fosr_pkg::fosr_ctrl_s c;
    c = base;
    {c.abs_a, c.abs_b} = 2'h3; // float arithmetic only
    ld(1'h0, 32'hC0400000, 32'hBF800000);
    rd(c);
    `CHK("operand_a", 32'h40400000, operand_a)
    `CHK("operand_b", 32'h3F800000, operand_b)
    {c.abs_a, c.abs_b} = 2'h0;
    rd(c);
    `CHK("operand_a", 32'hC0400000, operand_a)
    `CHK("operand_b", 32'hBF800000, operand_b)
  endtask
  task automatic t_signed();
    fosr_pkg::fosr_ctrl_s c;
    c = base;
    // operands arrive already wrapped upstream
    {c.signed_a, c.signed_b, c.wrap_a, c.wrap_b} = 4'hF;
    {c.dividend_wrapped, c.divisor_wrapped} = 2'h3;
    rd(c);
    `CHK("signed_a", 1'h0, operand_ctrl.signed_a)
    `CHK("wrap_a", 1'h1, operand_ctrl.wrap_a)
    `CHK("wrap_b", 1'h1, operand_ctrl.wrap_b)
    `CHK("dividend", 1'h1, operand_ctrl.dividend_wrapped)
    `CHK("divisor", 1'h1, operand_ctrl.divisor_wrapped)
    c.single_precision = 1'h0;
    // flags low again outside divide
    {c.signed_b, c.wrap_a, c.wrap_b} = 3'h0;
    {c.dividend_wrapped, c.divisor_wrapped} = 2'h0;
    rd(c);
    `CHK("signed_a", 1'h1, operand_ctrl.signed_a)
    `CHK("signed_b", 1'h0, operand_ctrl.signed_b)
  endtask
  task automatic t_multi();
    fosr_pkg::fosr_ctrl_s c;
    c = base;
    {c.sel_a, c.sel_b, c.multicycle} = 3'h7;
    ld(1'h1, 32'h00000005, 32'h00000006);
    read_operands = 1'h1;
    ctrl_in = c;
    @(negedge mclk);
    load_a = 1'h0; // registers untouched while busy
    load_b = 1'h0;
    ctrl_in.sel_a = 1'h0;
    for (int k = 1; k < MC; k++) begin
      `CHK("busy", 1'h1, busy)
      `CHK("operand_a", 32'h00000005, operand_a)
      @(negedge mclk);
    end
    read_operands = 1'h0;
    `CHK("busy", 1'h0, busy)
    `CHK("operand_a", 32'h00000005, operand_a)
    @(negedge mclk);
  endtask
  task automatic t_round();
    for (int m = 0; m < 4; m++) begin
      rnd(1'h1, 2'(m), fr(3'h0, 11'h080, 24'h800000),
        32'h40000000);
    end
    `CHK("inexact", 1'h0, result_inexact)
    `CHK("overflow", 1'h0, result_overflow)
    rnd(1'h1, 2'h0, fr(3'h2, 11'h080, 24'h800001), 32'h40000002);
    `CHK("inexact", 1'h1, result_inexact)
    rnd(1'h1, 2'h0, fr(3'h2, 11'h080, 24'h800000), 32'h40000000);
    rnd(1'h1, 2'h0, fr(3'h2, 11'h0FE, 24'hFFFFFF), 32'h7F800000);
    `CHK("overflow", 1'h1, result_overflow)
    rnd(1'h1, 2'h1, fr(3'h7, 11'h080, 24'h800000), 32'hC0000000);
    rnd(1'h1, 2'h1, fr(3'h0, 11'h0FF, 24'h800000), 32'h7F7FFFFF);
    rnd(1'h1, 2'h2, fr(3'h1, 11'h080, 24'h800000), 32'h40000001);
    rnd(1'h1, 2'h2, fr(3'h0, 11'h0FF, 24'h800000), 32'h7F800000);
    rnd(1'h1, 2'h2, fr(3'h4, 11'h0FF, 24'h800000), 32'hFF7FFFFF);
    rnd(1'h1, 2'h3, fr(3'h5, 11'h080, 24'h800000), 32'hC0000001);
    rnd(1'h1, 2'h3, fr(3'h0, 11'h0FF, 24'h800000), 32'h7F7FFFFF);
    rnd(1'h1, 2'h3, fr(3'h4, 11'h0FF, 24'h800000), 32'hFF800000);
    rnd(1'h0, 2'h1, fx(P_ODD, 1'h0), 32'h12345679);
    rnd(1'h0, 2'h0, fx(P_ODD, 1'h0), 32'h1234567A);
    rnd(1'h0, 2'h0, fx(P_EVEN, 1'h0), 32'h12345678);
    rnd(1'h0, 2'h0, fx(P_SH, 1'h1), 32'h12345678);
    rnd(1'h0, 2'h2, fx(P_EVEN, 1'h0), 32'h12345678);
    `CHK("round_illegal", 1'h1, round_illegal)
  endtask
  // ==========
  // sequence and watchdog
  initial begin
    base = '0;
    {base.use_a, base.use_b, base.single_precision} = 3'h7;
    repeat (8) @(negedge mclk);
    reset = 1'h0;
    @(negedge mclk);
    t_select();
    t_unused();
    t_abs();
    t_signed();
    t_multi();
    t_round();
    results();
  end
  // far above the hundred or so cycles the run needs
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    results();
  end
endmodule // tb_top
